// ---- sdram_timing_pkg.sv ----
// package: speed-bin limits, mode-register fields and carriers for the sdram timing core
package sdram_timing_pkg;

    // clock rate
    localparam real CLK_PERIOD_NS = 4.0;

    // speed-bin minima and maxima in ns
    localparam real ACCESS_MIN_FAST_NS  = 13.75;
    localparam real ACCESS_MIN_SLOW_NS  = 13.5;
    localparam real ACCESS_MAX_NS       = 20.0;
    localparam real ACT_TO_ACT_FAST_NS  = 48.75;
    localparam real ACT_TO_ACT_SLOW_NS  = 49.5;
    localparam real ACT_TO_PRE_FAST_NS  = 35.0;
    localparam real ACT_TO_PRE_SLOW_NS  = 36.0;
    localparam real DOWNBIN_LIMIT_NS    = 13.125;

    // counts derived from the clock; least rounds up, longest rounds down
    localparam int ACCESS_MIN_FAST_CYC = int'($ceil(ACCESS_MIN_FAST_NS / CLK_PERIOD_NS));
    localparam int ACCESS_MIN_SLOW_CYC = int'($ceil(ACCESS_MIN_SLOW_NS / CLK_PERIOD_NS));
    localparam int ACCESS_MAX_CYC      = int'($floor(ACCESS_MAX_NS / CLK_PERIOD_NS));
    localparam int DOWNBIN_LIMIT_CYC   = int'($floor(DOWNBIN_LIMIT_NS / CLK_PERIOD_NS));

    // latency chosen inside the window; down-binning parts must not exceed its limit
    localparam logic [3:0] ACCESS_DELAY_FAST = 4'(ACCESS_MIN_FAST_CYC);
    localparam logic [3:0] ACCESS_DELAY_SLOW = 4'(ACCESS_MIN_SLOW_CYC);
    localparam logic [3:0] DOWNBIN_DELAY     = 4'(DOWNBIN_LIMIT_CYC);

    // read latency and write latency codes
    localparam logic [3:0] READ_LAT_6  = 4'h6;
    localparam logic [3:0] READ_LAT_11 = 4'hb;
    localparam logic [3:0] READ_LAT_10 = 4'ha;
    localparam logic [3:0] WRITE_LAT_5 = 4'h5;
    localparam logic [3:0] WRITE_LAT_7 = 4'h7;
    localparam logic [3:0] WRITE_LAT_8 = 4'h8;

    // mode register zero fields
    localparam int ZERO_BL_LSB  = 0;
    localparam int ZERO_ORDER   = 3;
    localparam int ZERO_PD_EXIT = 12;
    localparam logic [1:0] BURST_OF_EIGHT_CODE = 2'h0;

    // mode register one fields
    localparam int ONE_DRV_LO   = 1;
    localparam int ONE_DRV_HI   = 5;
    localparam int ONE_NOM_LO   = 2;
    localparam int ONE_NOM_MID  = 6;
    localparam int ONE_NOM_HI   = 9;
    localparam int ONE_OUT_OFF  = 12;
    localparam logic [1:0] DRIVE_NORMAL_CODE = 2'h1;
    localparam logic [2:0] NOM_TERM_CODE     = 3'h3;

    // mode register two fields
    localparam int TWO_AUTO_RATE  = 6;
    localparam int TWO_TEMP_RANGE = 7;
    localparam int TWO_WT_LO      = 9;
    localparam logic [1:0] WRITE_TERM_CODE = 2'h2;

    // reset values
    localparam logic [15:0] MODE_RESET = 16'h0000;

    // mode register select codes
    localparam logic [1:0] SEL_ZERO = 2'h0;
    localparam logic [1:0] SEL_ONE  = 2'h1;
    localparam logic [1:0] SEL_TWO  = 2'h2;

    typedef struct packed {
        logic        burst_of_eight;
        logic        sequential_order;
        logic        fast_pd_exit;
        logic        output_enabled;
        logic        drive_normal;
        logic        nominal_termination;
        logic        auto_self_refresh_rate;
        logic        self_refresh_temp_range;
        logic        write_termination;
    } mode_status_s;

    typedef struct packed {
        logic        valid;
        logic [1:0]  sel;
        logic [15:0] value;
    } mode_write_s;

endpackage

// ---- sdram_timing_core.sv ----
// sdram timing core: mode registers and read-access latency counted on mclk, commands taken on link clock rises
`timescale 1ns/1ps

// Contract
// - first read data comes within the access window after the read
// - bits 1 and 0 of register zero at 00 fix burst of eight
// - bit 12 of register zero picks slow or fast power-down exit
// - bit 6 of register two turns auto self-refresh rate off or on
// - bit 7 of register two picks normal or extended temperature range
// - bit 3 of register zero clear selects sequential burst order
// - register one bit 12 clear enables outputs; bits 5,1 at 01 normal drive
// - register one bits 9,6,2 at 011 enable nominal termination
// - register two bits 10,9 at 10 enable write termination
// - down-binning parts keep the access minimum at 13.125 ns or less; no precharge minimum is kept
module sdram_timing_core (
    // clock and reset
    input  wire logic                         mclk,
    input  wire logic                         sys_rst,
    // link from the controller
    input  wire logic                         link_clk,
    input  wire logic                         mode_wr,
    input  wire logic [1:0]                   mode_sel,
    input  wire logic [15:0]                  mode_value,
    input  wire logic                         read_cmd,
    // configuration straps
    input  wire logic                         fast_bin,
    input  wire logic                         downbin_part,
    // status and data timing
    output logic                              read_data_valid,
    output logic                              setting_reserved,
    output sdram_timing_pkg::mode_status_s    mode_status
);
    import sdram_timing_pkg::*;

    // link sampling: two flops, then edge detect on the second
    logic [2:0]  clk_sync_q;
    logic [1:0]  wr_sync_q;
    logic [1:0]  rd_sync_q;
    logic [1:0]  bin_sync_q;
    logic [1:0]  dbin_sync_q;
    logic [1:0]  sel_s1_q;
    logic [1:0]  sel_s2_q;
    logic [15:0] val_s1_q;
    logic [15:0] val_s2_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_sync_q  <= 3'h0;
            wr_sync_q   <= 2'h0;
            rd_sync_q   <= 2'h0;
            bin_sync_q  <= 2'h0;
            dbin_sync_q <= 2'h0;
            sel_s1_q    <= 2'h0;
            sel_s2_q    <= 2'h0;
            val_s1_q    <= MODE_RESET;
            val_s2_q    <= MODE_RESET;
        end else begin
            clk_sync_q  <= {clk_sync_q[1:0], link_clk};
            wr_sync_q   <= {wr_sync_q[0], mode_wr};
            rd_sync_q   <= {rd_sync_q[0], read_cmd};
            bin_sync_q  <= {bin_sync_q[0], fast_bin};
            dbin_sync_q <= {dbin_sync_q[0], downbin_part};
            sel_s1_q    <= mode_sel;
            sel_s2_q    <= sel_s1_q;
            val_s1_q    <= mode_value;
            val_s2_q    <= val_s1_q;
        end
    end

    wire link_rise = clk_sync_q[1] & ~clk_sync_q[2];

    mode_write_s wr_req;
    assign wr_req.valid = link_rise & wr_sync_q[1];
    assign wr_req.sel   = sel_s2_q;
    assign wr_req.value = val_s2_q;
    wire         rd_take = link_rise & rd_sync_q[1];

    // mode registers
    logic [15:0] mr0_q;
    logic [15:0] mr1_q;
    logic [15:0] mr2_q;
    logic        reserved_q;

    // reserved: burst field code 3, drive codes above normal, write termination code 3, or select code 3
    function automatic logic is_reserved(input logic [1:0] sel, input logic [15:0] v);
        logic r;
        r = 1'b0;
        case (sel)
            SEL_ZERO: r = (v[ZERO_BL_LSB +: 2] == 2'h3);
            SEL_ONE:  r = ({v[ONE_DRV_HI], v[ONE_DRV_LO]} > DRIVE_NORMAL_CODE);
            SEL_TWO:  r = (v[TWO_WT_LO +: 2] == 2'h3);
            default: r = 1'b1;
        endcase
        return r;
    endfunction

    wire wr_bad = is_reserved(wr_req.sel, wr_req.value);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mr0_q      <= MODE_RESET;
            mr1_q      <= MODE_RESET;
            mr2_q      <= MODE_RESET;
            reserved_q <= 1'b0;
        end else if (wr_req.valid) begin
            reserved_q <= wr_bad;
            if (!wr_bad && wr_req.sel == SEL_ZERO)
                mr0_q <= wr_req.value;
            if (!wr_bad && wr_req.sel == SEL_ONE)
                mr1_q <= wr_req.value;
            if (!wr_bad && wr_req.sel == SEL_TWO)
                mr2_q <= wr_req.value;
        end
    end

    // field decode
    mode_status_s status_d;
    assign status_d.burst_of_eight   = (mr0_q[ZERO_BL_LSB +: 2] == BURST_OF_EIGHT_CODE);
    assign status_d.sequential_order = ~mr0_q[ZERO_ORDER];
    assign status_d.fast_pd_exit     = mr0_q[ZERO_PD_EXIT];
    assign status_d.output_enabled   = ~mr1_q[ONE_OUT_OFF];
    assign status_d.drive_normal =
        ({mr1_q[ONE_DRV_HI], mr1_q[ONE_DRV_LO]} == DRIVE_NORMAL_CODE);
    assign status_d.nominal_termination =
        ({mr1_q[ONE_NOM_HI], mr1_q[ONE_NOM_MID], mr1_q[ONE_NOM_LO]} == NOM_TERM_CODE);
    assign status_d.auto_self_refresh_rate  = mr2_q[TWO_AUTO_RATE];
    assign status_d.self_refresh_temp_range = mr2_q[TWO_TEMP_RANGE];
    assign status_d.write_termination =
        (mr2_q[TWO_WT_LO +: 2] == WRITE_TERM_CODE);

    // access latency per bin; down-binning parts use the tighter minimum
    wire [3:0] access_delay = dbin_sync_q[1] ? DOWNBIN_DELAY :
                              (bin_sync_q[1] ? ACCESS_DELAY_FAST : ACCESS_DELAY_SLOW);

    // read access sequencer
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b01,
        ACC_WAIT = 2'b10
    } access_state_e;

    access_state_e acc_q;
    access_state_e acc_d;
    logic [3:0]    acc_cnt_q;
    logic [3:0]    acc_cnt_d;
    logic          data_valid_d;

    always_comb begin
        acc_d        = acc_q;
        acc_cnt_d    = acc_cnt_q;
        data_valid_d = 1'b0;
        case (acc_q)
            ACC_IDLE: begin
                if (rd_take) begin
                    acc_d     = ACC_WAIT;
                    acc_cnt_d = access_delay - 4'h1;
                end
            end
            ACC_WAIT: begin
                if (acc_cnt_q == 4'h0) begin
                    data_valid_d = 1'b1;
                    acc_d        = ACC_IDLE;
                end else begin
                    acc_cnt_d = acc_cnt_q - 4'h1;
                end
            end
            default: acc_d = ACC_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q            <= ACC_IDLE;
            acc_cnt_q        <= 4'h0;
            read_data_valid  <= 1'b0;
            setting_reserved <= 1'b0;
            mode_status      <= '0;
        end else begin
            acc_q            <= acc_d;
            acc_cnt_q        <= acc_cnt_d;
            read_data_valid  <= data_valid_d;
            setting_reserved <= reserved_q;
            mode_status      <= status_d;
        end
    end

endmodule // sdram_timing_core

// ---- sdram_timing_monitor.sv ----
// checker: read timing and mode fields of the timing core
`timescale 1ns/1ps
module sdram_timing_monitor (
    // clock and reset
    input wire logic         mclk,
    input wire logic         sys_rst,
    // link and straps
    input wire logic         link_clk,
    input wire logic         mode_wr,
    input wire logic [1:0]   mode_sel,
    input wire logic [15:0]  mode_value,
    input wire logic         read_cmd,
    input wire logic         downbin_part,
    // outputs watched
    input wire logic         read_data_valid,
    input wire sdram_timing_pkg::mode_status_s mode_status
);
    import sdram_timing_pkg::*;
    logic [2:0] lk_q;
    wire [15:0] v   = mode_value;
    wire        tk  = lk_q[1] & ~lk_q[2];
    wire        rd  = tk & read_cmd;
    wire        wr0 = tk & mode_wr & (mode_sel == 2'h0) & (v[1:0] != 2'h3);
    wire        wr1 = tk & mode_wr & (mode_sel == 2'h1) & ({v[5], v[1]} < 2'h2);
    wire        wr2 = tk & mode_wr & (mode_sel == 2'h2) & (v[10:9] != 2'h3);
    // link edge found as the core finds it
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lk_q <= 3'h0;
        end else begin
            lk_q <= {lk_q[1:0], link_clk};
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    sequence s_wait_rd;
        ##1 !read_data_valid [*2];
    endsequence
    a_pulse_single: assert property (read_data_valid |=> !read_data_valid)
        else $error("read data valid longer than one cycle");
    a_read_window: assert property (rd & !downbin_part |-> s_wait_rd ##1
        !read_data_valid ##[1:3] read_data_valid) else $error("read data outside access window");
    a_downbin_window: assert property (rd & downbin_part |-> s_wait_rd ##[1:3] read_data_valid)
        else $error("down-bin read data outside window");
    a_burst_eight: assert property (wr0 & (v[1:0] == 2'h0) |-> ##3 mode_status.burst_of_eight)
        else $error("burst of eight not set");
    a_pd_exit: assert property (wr0 |-> ##3 mode_status.fast_pd_exit == v[12])
        else $error("power-down exit wrong");
    a_burst_order: assert property (wr0 |-> ##3 mode_status.sequential_order == !v[3])
        else $error("burst order wrong");
    a_out_drive: assert property (wr1 |-> ##3 mode_status.output_enabled == !v[12]
        && mode_status.drive_normal == ({v[5], v[1]} == 2'h1)) else $error("output or drive wrong");
    a_nom_term: assert property (wr1 |-> ##3 mode_status.nominal_termination
        == ({v[9], v[6], v[2]} == 3'h3)) else $error("nominal termination wrong");
    a_self_refresh: assert property (wr2 |-> ##3 mode_status.auto_self_refresh_rate == v[6]
        && mode_status.self_refresh_temp_range == v[7]) else $error("self refresh fields wrong");
    a_write_term: assert property (wr2 |-> ##3 mode_status.write_termination
        == (v[10:9] == 2'h2)) else $error("write termination wrong");
endmodule // sdram_timing_monitor

bind sdram_timing_core sdram_timing_monitor i_sdram_timing_monitor (
    .mclk(mclk), .sys_rst(sys_rst), .link_clk(link_clk), .mode_wr(mode_wr),
    .mode_sel(mode_sel), .mode_value(mode_value), .read_cmd(read_cmd),
    .downbin_part(downbin_part), .read_data_valid(read_data_valid), .mode_status(mode_status)
);

// ---- sdram_ctrl_model.sv ----
// controller model: one command per link clock pulse, 187.5 ns period
`timescale 1ns/1ps
module sdram_ctrl_model (
    // link to the core
    output logic        link_clk,
    output logic        mode_wr,
    output logic [1:0]  mode_sel,
    output logic [15:0] mode_value,
    output logic        read_cmd
);
    initial begin
        {link_clk, mode_wr, mode_sel, mode_value, read_cmd} = 21'h00_0000;
    end
    // link clock stands still between commands
    task automatic send(input logic wr, input logic rd, input logic [1:0] sel,
                        input logic [15:0] val);
        {mode_wr, read_cmd, mode_sel, mode_value} = {wr, rd, sel, val};
        // one command per 187.5 ns keeps every spacing minimum in whole cycles
        #62.5 link_clk = 1'b1;
        // 4 ns core period is outside every latency pairing, so none is programmed
        #62.5 link_clk = 1'b0;
        // released lines do not keep the last value
        {mode_wr, read_cmd, mode_sel, mode_value} = {2'h0, ~sel, ~val};
        #62.5;
    endtask
endmodule // sdram_ctrl_model

// ---- test_sdram_timing_core.sv ----
// testbench: mode writes, reserved codes and read timing per strap
`timescale 1ns/1ps
module test_sdram_timing_core;
    import sdram_timing_pkg::*;
    logic         mclk;
    logic         sys_rst;
    logic         fast_bin;
    logic         downbin_part;
    logic         link_clk;
    logic         mode_wr;
    logic         read_cmd;
    logic [1:0]   mode_sel;
    logic [15:0]  mode_value;
    logic         read_data_valid;
    logic         setting_reserved;
    mode_status_s mode_status;
    logic [15:0]  mr [3];
    int           errors;
    int           n_checks;
    int           cyc;
    // {reserved, select, value}
    localparam logic [18:0] WT [10] = '{19'h0_1000, 19'h0_0009, 19'h4_0003, 19'h1_0046,
        19'h1_1000, 19'h5_0020, 19'h2_04c0, 19'h2_0200, 19'h6_0600, 19'h7_0000};

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    sdram_ctrl_model i_sdram_ctrl_model (.link_clk(link_clk), .mode_wr(mode_wr),
        .mode_sel(mode_sel), .mode_value(mode_value), .read_cmd(read_cmd));
    sdram_timing_core i_sdram_timing_core (.mclk(mclk), .sys_rst(sys_rst),
        .link_clk(link_clk), .mode_wr(mode_wr), .mode_sel(mode_sel),
        .mode_value(mode_value), .read_cmd(read_cmd), .fast_bin(fast_bin),
        .downbin_part(downbin_part), .read_data_valid(read_data_valid),
        .setting_reserved(setting_reserved), .mode_status(mode_status));

    function automatic mode_status_s exp_st();
        return {mr[0][1:0] == 2'h0, !mr[0][3], mr[0][12], !mr[1][12],
            {mr[1][5], mr[1][1]} == 2'h1, {mr[1][9], mr[1][6], mr[1][2]} == 3'h3,
            mr[2][6], mr[2][7], mr[2][10:9] == 2'h2};
    endfunction

    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr_mode(input logic [18:0] e);
        @(negedge mclk);
        i_sdram_ctrl_model.send(1'b1, 1'b0, e[17:16], e[15:0]);
        if (!e[18]) mr[e[17:16]] = e[15:0];
        chk("mode status", exp_st(), mode_status);
        chk("reserved flag", 9'(e[18]), 9'(setting_reserved));
    endtask

    task automatic rd_chk(input int lat);
        int n;
        @(negedge mclk);
        fork
            i_sdram_ctrl_model.send(1'b0, 1'b1, 2'h0, 16'h0000);
            begin
                @(posedge link_clk);
                n = 0;
                do begin
                    @(negedge mclk);
                    n++;
                end while (read_data_valid !== 1'b1 && n < 40);
                chk("read delay in window", 9'h001, 9'(n >= lat + 4 && n <= lat + 5));
                @(negedge mclk);
                chk("read pulse end", 9'h000, 9'(read_data_valid));
            end
        join
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        {sys_rst, fast_bin, downbin_part} = 3'h6;
        mr = '{default: 16'h0000};
        repeat (6) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (4) @(negedge mclk);
        chk("reset status", exp_st(), mode_status);
        foreach (WT[i]) wr_mode(WT[i]);
        for (int i = 0; i < 3; i++) begin
            fast_bin = (i != 1);
            downbin_part = (i == 2);
            rd_chk(i == 2 ? 3 : 4);
        end
        finish_test();
    end
endmodule // test_sdram_timing_core
